// >>> rtl/rlyop_port.sv
// Relay output port: jumper-selected I/O decode and two write-only relay control bytes
// How it works
// - Jumper code picks base 0x240 upward by 0x40
// - Factory jumper code gives base 0x300
// - Decode only base and base plus one
// - Base write loads relays zero to seven
// - Base plus one loads relays eight-fifteen
// - Bit one energises its relay coil
// - Bit zero releases its relay coil
// - Power-up clears both control bytes
// - Bus reset clears both control bytes
// - Each write replaces the whole byte
// - Only eight-bit bus signals are used
// - No extension connector signal is used
`default_nettype none
module rlyop_port
    import rlyop_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic bus_reset,
    input wire rlyop_bus_type bus_in,
    input wire logic [2:0] address_jumper_block,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic [15:0] relay_drive_bits
);
    rlyop_bus_type bus_meta_ff;
    rlyop_bus_type bus_sync_ff;
    logic [2:0] jmp_meta_ff;
    logic [2:0] jmp_sync_ff;
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic iow_n_prev_ff;
    logic [7:0] ctrl_low_ff;
    logic [7:0] ctrl_high_ff;
    logic [9:0] base_addr;
    logic decode_on;
    logic hit_low;
    logic hit_high;
    logic write_edge;

    // Pins are outside the core clock domain
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_meta_ff <= '{addr: 10'h0000, data: 8'h00, iow_n: 1'b1, ior_n: 1'b1, aen: 1'b1};
            bus_sync_ff <= '{addr: 10'h0000, data: 8'h00, iow_n: 1'b1, ior_n: 1'b1, aen: 1'b1};
        end else begin
            bus_meta_ff <= bus_in;
            bus_sync_ff <= bus_meta_ff;
        end
    end

    // Decode stays off until the jumper code has crossed over
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            jmp_meta_ff <= RLYOP_JUMPER_DISABLED;
            jmp_sync_ff <= RLYOP_JUMPER_DISABLED;
        end else begin
            jmp_meta_ff <= address_jumper_block;
            jmp_sync_ff <= jmp_meta_ff;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= 1'b1;
        end else begin
            rst_meta_ff <= bus_reset;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            iow_n_prev_ff <= 1'b1;
        end else begin
            iow_n_prev_ff <= bus_sync_ff.iow_n;
        end
    end

    // Base rises by one step per jumper code
    always_comb begin
        base_addr = RLYOP_BASE_FIRST + 10'(jmp_sync_ff) * RLYOP_BASE_STEP;
    end
    assign decode_on = (jmp_sync_ff != RLYOP_JUMPER_DISABLED);
    // Only main-connector address lines and strobes take part
    assign hit_low = decode_on && !bus_sync_ff.aen
                     && (bus_sync_ff.addr == base_addr + RLYOP_OFS_CTRL_LOW);
    assign hit_high = decode_on && !bus_sync_ff.aen
                      && (bus_sync_ff.addr == base_addr + RLYOP_OFS_CTRL_HIGH);
    // Data is latched at the trailing edge of the write strobe
    assign write_edge = !iow_n_prev_ff && bus_sync_ff.iow_n;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_low_ff <= RLYOP_CTRL_RESET;
        end else if (rst_sync_ff) begin
            ctrl_low_ff <= RLYOP_CTRL_RESET;
        end else if (write_edge && hit_low) begin
            ctrl_low_ff <= bus_sync_ff.data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_high_ff <= RLYOP_CTRL_RESET;
        end else if (rst_sync_ff) begin
            ctrl_high_ff <= RLYOP_CTRL_RESET;
        end else if (write_edge && hit_high) begin
            ctrl_high_ff <= bus_sync_ff.data;
        end
    end

    // A set bit energises the coil, a clear bit releases it
    for (genvar gi = 0; gi < 16; gi++) begin : g_relay
        if (gi < 8) begin : g_low
            assign relay_drive_bits[gi] = ctrl_low_ff[gi];
        end else begin : g_high
            assign relay_drive_bits[gi] = ctrl_high_ff[gi - 8];
        end
    end
    assign data_out = 8'h00;
    assign data_oe = 1'b0;

    a_reset_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
        rst_sync_ff |=> relay_drive_bits == 16'h0000)
        else $error("bus reset did not clear relays");
    a_low_write_loads: assert property (@(posedge core_clk) disable iff (!rst_n)
        write_edge && hit_low && !rst_sync_ff |=> ctrl_low_ff == $past(bus_sync_ff.data))
        else $error("low byte not loaded");
    a_high_write_loads: assert property (@(posedge core_clk) disable iff (!rst_n)
        write_edge && hit_high && !rst_sync_ff |=> ctrl_high_ff == $past(bus_sync_ff.data))
        else $error("high byte not loaded");
    a_other_addr_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !hit_low && !hit_high && !rst_sync_ff |=> $stable(relay_drive_bits))
        else $error("relays changed without a decoded write");
    a_disabled_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        jmp_sync_ff == RLYOP_JUMPER_DISABLED && !rst_sync_ff |=> $stable(relay_drive_bits))
        else $error("decode active with all jumpers in");
    a_never_drives: assert property (@(posedge core_clk) disable iff (!rst_n)
        !data_oe)
        else $error("data bus driven");
    a_factory_base: assert property (@(posedge core_clk) disable iff (!rst_n)
        jmp_sync_ff == RLYOP_JUMPER_FACTORY |-> base_addr == RLYOP_FACTORY_BASE)
        else $error("factory base wrong");
    a_base_step: assert property (@(posedge core_clk) disable iff (!rst_n)
        decode_on |-> base_addr[5:0] == 6'h00 && base_addr >= RLYOP_BASE_FIRST)
        else $error("base not on step grid");
    a_map_relays: assert property (@(posedge core_clk) disable iff (!rst_n)
        relay_drive_bits[15:8] == ctrl_high_ff && relay_drive_bits[7:0] == ctrl_low_ff)
        else $error("relay mapping wrong");

    // Decode, reset, write-path and read-path checks
    a_aen_blocks: assert property (@(posedge core_clk) disable iff (!rst_n)
        bus_sync_ff.aen && !rst_sync_ff |=> $stable(relay_drive_bits))
        else $error("relays changed during DMA cycle");
    a_read_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
        !bus_sync_ff.ior_n && iow_n_prev_ff && !rst_sync_ff |=> $stable(relay_drive_bits))
        else $error("read changed relays");
    a_data_out_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        data_out == 8'h00)
        else $error("read data not idle");
    a_no_strobe_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !write_edge && !rst_sync_ff |=> $stable(relay_drive_bits))
        else $error("relays changed without a write strobe");
    a_reset_priority: assert property (@(posedge core_clk) disable iff (!rst_n)
        rst_sync_ff && write_edge |=> relay_drive_bits == 16'h0000)
        else $error("write won over bus reset");
    a_low_keeps_high: assert property (@(posedge core_clk) disable iff (!rst_n)
        write_edge && hit_low && !rst_sync_ff |=> $stable(ctrl_high_ff))
        else $error("low write touched high byte");
    a_high_keeps_low: assert property (@(posedge core_clk) disable iff (!rst_n)
        write_edge && hit_high && !rst_sync_ff |=> $stable(ctrl_low_ff))
        else $error("high write touched low byte");
    a_hits_exclusive: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(hit_low && hit_high))
        else $error("both bytes decoded at once");
    a_hit_needs_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
        hit_low || hit_high |-> decode_on && !bus_sync_ff.aen)
        else $error("decode hit while blocked");
    a_high_offset_one: assert property (@(posedge core_clk) disable iff (!rst_n)
        hit_high |-> bus_sync_ff.addr[5:0] == 6'h01)
        else $error("high byte not at base plus one");
    a_low_on_grid: assert property (@(posedge core_clk) disable iff (!rst_n)
        hit_low |-> bus_sync_ff.addr[5:0] == 6'h00)
        else $error("low byte not at base");
    a_low_above_first: assert property (@(posedge core_clk) disable iff (!rst_n)
        hit_low |-> bus_sync_ff.addr >= RLYOP_BASE_FIRST)
        else $error("decode below lowest base");
    a_factory_low_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
        jmp_sync_ff == RLYOP_JUMPER_FACTORY && hit_low |-> bus_sync_ff.addr == RLYOP_FACTORY_BASE)
        else $error("factory low byte address wrong");
    a_edge_single: assert property (@(posedge core_clk) disable iff (!rst_n)
        write_edge |=> !write_edge)
        else $error("one strobe gave two writes");
    a_reset_bytes: assert property (@(posedge core_clk) disable iff (!rst_n)
        rst_sync_ff |=> ctrl_low_ff == RLYOP_CTRL_RESET && ctrl_high_ff == RLYOP_CTRL_RESET)
        else $error("control bytes not cleared");
    a_energise_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
        write_edge && hit_low && !rst_sync_ff && bus_sync_ff.data[0] |=> relay_drive_bits[0])
        else $error("relay zero not energised");
    a_release_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
        write_edge && hit_high && !rst_sync_ff && !bus_sync_ff.data[7] |=> !relay_drive_bits[15])
        else $error("relay fifteen not released");

    c_low_write: cover property (@(posedge core_clk) disable iff (!rst_n) write_edge && hit_low);
    c_high_write: cover property (@(posedge core_clk) disable iff (!rst_n) write_edge && hit_high);
    c_bus_reset: cover property (@(posedge core_clk) disable iff (!rst_n)
        rst_sync_ff && relay_drive_bits != 16'h0000);
    c_read_strobe: cover property (@(posedge core_clk) disable iff (!rst_n)
        !bus_sync_ff.ior_n && !bus_sync_ff.aen);
    c_disabled_write: cover property (@(posedge core_clk) disable iff (!rst_n)
        write_edge && !decode_on);
endmodule
`default_nettype wire

// >>> shared/rlyop_pkg.sv
// Constants and types shared by the relay output port
`default_nettype none
package rlyop_pkg;
    localparam int RLYOP_ADDR_W = 10;
    localparam int RLYOP_DATA_W = 8;
    localparam logic [9:0] RLYOP_BASE_FIRST = 10'h0240;
    localparam logic [9:0] RLYOP_BASE_STEP = 10'h0040;
    localparam logic [2:0] RLYOP_JUMPER_DISABLED = 3'h7;
    localparam logic [2:0] RLYOP_JUMPER_FACTORY = 3'h3;
    localparam logic [9:0] RLYOP_FACTORY_BASE = 10'h0300;
    localparam logic [9:0] RLYOP_OFS_CTRL_LOW = 10'h0000;
    localparam logic [9:0] RLYOP_OFS_CTRL_HIGH = 10'h0001;
    localparam logic [7:0] RLYOP_CTRL_RESET = 8'h00;
    localparam int RLYOP_RELAY_SETTLE_MS = 4;

    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] data;
        logic iow_n;
        logic ior_n;
        logic aen;
    } rlyop_bus_type;
endpackage
`default_nettype wire

// >>> tb/rlyop_host.sv
// Bus host model issuing port writes and reads
`default_nettype none
module rlyop_host
    import rlyop_pkg::*;
(
    input wire logic core_clk,
    input wire logic data_oe,
    output rlyop_bus_type bus
);
    timeunit 1ns / 1ps;
    logic seen;
    initial bus = {10'h0000, 8'h00, 3'h6};
    task automatic xfer(input logic [9:0] a, input logic [7:0] d, input logic e, input logic r);
        seen = 1'b0;
        @(posedge core_clk);
        bus <= {a, d, r, ~r, e};
        repeat (3) @(posedge core_clk) seen |= data_oe;
        bus <= {a, d, 2'h3, e};
        repeat (4) @(posedge core_clk);
        bus.data <= ~d;
        // Only coil bits are compared; contact settling is not modelled
        @(posedge core_clk);
        #1;
    endtask
endmodule
`default_nettype wire

// >>> tb/rlyop_port_tb.sv
// Self-checking bench for the relay output port
`default_nettype none
module rlyop_port_tb import rlyop_pkg::*; ;
    timeunit 1ns / 1ps;
    logic core_clk = 1'b0, rst_n = 1'b0, bus_reset = 1'b0, data_oe;
    logic [2:0] address_jumper_block = RLYOP_JUMPER_FACTORY;
    logic [9:0] base;
    logic [15:0] relay_drive_bits;
    logic [7:0] data_out;
    rlyop_bus_type bus_in;
    int miscompares = 0, check_count = 0;
    rlyop_port i_dut (.core_clk, .rst_n, .bus_reset, .bus_in, .address_jumper_block,
        .data_out, .data_oe, .relay_drive_bits);
    rlyop_host i_host (.core_clk, .data_oe, .bus(bus_in));
    initial forever #2 core_clk = ~core_clk;
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        miscompares += int'(g !== e);
        if (g !== e) $display("[ERR] %s expected %h seen %h", n, e, g);
    endtask
    task automatic results();
        if (miscompares == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        chk("reset", 16'h0000, relay_drive_bits);
        i_host.xfer(RLYOP_FACTORY_BASE, 8'hA5, 1'b0, 1'b0);
        i_host.xfer(10'h0301, 8'h3C, 1'b0, 1'b0);
        chk("factory", 16'h3CA5, relay_drive_bits);
        i_host.xfer(10'h0300, 8'hA5 & 8'hDF, 1'b0, 1'b0);
        chk("clear", 16'h3C85, relay_drive_bits);
        for (int c = 0; c < 7; c++) begin
            @(posedge core_clk);
            address_jumper_block <= 3'(c);
            base = 10'h0240 + 10'h0040 * 10'(c);
            i_host.xfer(base, 8'(c * 16), 1'b0, 1'b0);
            i_host.xfer(base + 10'h0001, 8'(c + 1), 1'b0, 1'b0);
            i_host.xfer(base - 10'h0001, 8'hFF, 1'b0, 1'b0);
            i_host.xfer(base + 10'h0002, 8'hFF, 1'b0, 1'b0);
            chk("decode", {8'(c + 1), 8'(c * 16)}, relay_drive_bits);
        end
        i_host.xfer(base, 8'h00, 1'b1, 1'b0);
        i_host.xfer(base, 8'h00, 1'b0, 1'b1);
        chk("dma_read", 16'h0760, relay_drive_bits | {15'h0000, i_host.seen});
        chk("read_data", 16'h0000, {8'h00, data_out});
        @(posedge core_clk);
        address_jumper_block <= RLYOP_JUMPER_DISABLED;
        i_host.xfer(base, 8'h00, 1'b0, 1'b0);
        chk("disabled", 16'h0760, relay_drive_bits);
        @(posedge core_clk);
        bus_reset <= 1'b1;
        repeat (5) @(posedge core_clk);
        bus_reset <= 1'b0;
        #1;
        chk("bus_reset", 16'h0000, relay_drive_bits);
        @(posedge core_clk);
        address_jumper_block <= RLYOP_JUMPER_FACTORY;
        i_host.xfer(RLYOP_FACTORY_BASE, 8'h5A, 1'b0, 1'b0);
        chk("pre_reset", 16'h005A, relay_drive_bits);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        chk("power_up", 16'h0000, relay_drive_bits);
        results();
    end
endmodule
`default_nettype wire
